//--- rtl/bgc_consts.svh
// constants for the bridge gate control block
`ifndef BGC_CONSTS_SVH
`define BGC_CONSTS_SVH

// ----------------------------------------------------------------
// phases and synchroniser
// ----------------------------------------------------------------
`define BGC_NUM_PHASES 3
`define BGC_SYNC_STAGES 2

// ----------------------------------------------------------------
// register map (word offsets are byte addresses)
// ----------------------------------------------------------------
`define BGC_ADDR_W 8
`define BGC_OFS_CTRL 8'h00
`define BGC_OFS_CFG 8'h04
`define BGC_OFS_STAT 8'h08
`define BGC_OFS_FAULT 8'h0C

// ctrl: bit 2p = low-side bit of phase p, bit 2p+1 = high-side bit
`define BGC_CTRL_RST 32'h0000_0000
// cfg: bit 0 direct mode, bit 1 gate outputs enabled by software
`define BGC_CFG_DIRECT_BIT 0
`define BGC_CFG_GATE_EN_BIT 1
`define BGC_CFG_RST 32'h0000_0001
// fault: bits 0..2 high-side, bits 8..10 low-side, write one to clear
`define BGC_FAULT_HS_LSB 0
`define BGC_FAULT_LS_LSB 8

`endif

//--- rtl/bgc_pkg.sv
// types shared by the bridge gate control block
package bgc_pkg;

  // ----------------------------------------------------------------
  // per-phase command and gate pair
  // ----------------------------------------------------------------
  typedef struct packed {
    logic high;
    logic low;
  } bgc_pair_s;

  typedef enum logic [1:0] {
    BGC_PH_OFF,
    BGC_PH_SINK,
    BGC_PH_SOURCE,
    BGC_PH_BLOCKED
  } bgc_phase_e;

  // ----------------------------------------------------------------
  // register bus request
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bgc_bus_s;

endpackage : bgc_pkg

//--- rtl/bgc_phase.sv
// one phase: command decode and gate drive
module bgc_phase (
  input wire logic clk,
  input wire logic rst,
  input wire bgc_pkg::bgc_pair_s cmd,
  input wire logic gateEnable,
  output logic highSideGateOut,
  output logic lowSideGateOut,
  output bgc_pkg::bgc_phase_e phaseState
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  bgc_pkg::bgc_phase_e state;

  always_comb begin
    case ({cmd.high, cmd.low})
      2'b00: state = bgc_pkg::BGC_PH_OFF;
      2'b01: state = bgc_pkg::BGC_PH_SINK;
      2'b10: state = bgc_pkg::BGC_PH_SOURCE;
      default: state = bgc_pkg::BGC_PH_BLOCKED;
    endcase
  end

  // ----------------------------------------------------------------
  // gate flops
  // ----------------------------------------------------------------
  // registered so a glitch on the decode never reaches a gate
  always_ff @(posedge clk) begin
    if (rst || !gateEnable) begin
      highSideGateOut <= 1'b0;
      lowSideGateOut <= 1'b0;
    end else begin
      highSideGateOut <= (state == bgc_pkg::BGC_PH_SOURCE);
      lowSideGateOut <= (state == bgc_pkg::BGC_PH_SINK);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      phaseState <= bgc_pkg::BGC_PH_OFF;
    end else begin
      phaseState <= state;
    end
  end

endmodule : bgc_phase

//--- rtl/bgc_bridge_gate_ctrl.sv
// bridge gate control top: pin sync, command merge, faults, registers
// Behaviour
// - each phase decoded and driven independently
// - high-side command is pin OR bit
// - low-side command is pin OR bit
// - both commands low: both gates off
// - low only: low gate on, high off
// - high only: high gate on, low off
// - both commands high: both gates off
// - disabled outputs force every gate low
// - flag high-side drain-source fault from comparator
// - flag low-side drain-source fault from comparator
// - enable low in direct mode disables gates
//
// Decided for this implementation: strobed register access and the placing of the registers.
`include "bgc_consts.svh"

module bgc_bridge_gate_ctrl #(
  parameter int NUM_PHASES = `BGC_NUM_PHASES,
  parameter int SYNC_STAGES = `BGC_SYNC_STAGES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [NUM_PHASES-1:0] highSideCmdPin,
  input wire logic [NUM_PHASES-1:0] lowSideCmdPin,
  input wire logic enablePin,
  input wire logic [NUM_PHASES-1:0] highSideDsOver,
  input wire logic [NUM_PHASES-1:0] lowSideDsOver,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  output logic [NUM_PHASES-1:0] highSideGateOut,
  output logic [NUM_PHASES-1:0] lowSideGateOut,
  output logic [NUM_PHASES-1:0] highSideDsFault,
  output logic [NUM_PHASES-1:0] lowSideDsFault
);

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  // register layout holds at most eight phases per field
  if (NUM_PHASES < 1 || NUM_PHASES > 8) begin : gBadPhases
    $error("NUM_PHASES must be 1 to 8");
  end
  if (SYNC_STAGES < 2) begin : gBadSync
    $error("SYNC_STAGES must be at least 2");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] widen(input logic [NUM_PHASES-1:0] v);
    logic [31:0] r;
    r = 32'h0000_0000;
    r[NUM_PHASES-1:0] = v;
    return r;
  endfunction : widen

  bgc_pkg::bgc_bus_s bus;
  assign bus.addr = regAddr;
  assign bus.wdata = regWdata;
  assign bus.wr = regWr;
  assign bus.rd = regRd;

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  // first stage feeds only the next stage, never the logic
  logic [SYNC_STAGES-1:0][NUM_PHASES-1:0] hiSync_q;
  logic [SYNC_STAGES-1:0][NUM_PHASES-1:0] loSync_q;
  logic [SYNC_STAGES-1:0] enSync_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      hiSync_q <= '0;
      loSync_q <= '0;
      enSync_q <= '0;
    end else begin
      hiSync_q <= {hiSync_q[SYNC_STAGES-2:0], highSideCmdPin};
      loSync_q <= {loSync_q[SYNC_STAGES-2:0], lowSideCmdPin};
      enSync_q <= {enSync_q[SYNC_STAGES-2:0], enablePin};
    end
  end

  logic [NUM_PHASES-1:0] hiPin;
  logic [NUM_PHASES-1:0] loPin;
  logic enable;
  assign hiPin = hiSync_q[SYNC_STAGES-1];
  assign loPin = loSync_q[SYNC_STAGES-1];
  assign enable = enSync_q[SYNC_STAGES-1];

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  localparam logic [31:0] CFG_RST = `BGC_CFG_RST;
  logic [NUM_PHASES-1:0] highSideCmdBit_q;
  logic [NUM_PHASES-1:0] lowSideCmdBit_q;
  logic directMode_q;
  logic gateEnSw_q;

  logic ctrlHit;
  logic cfgHit;
  logic faultHit;
  logic statHit;
  assign ctrlHit = (bus.addr == `BGC_OFS_CTRL);
  assign cfgHit = (bus.addr == `BGC_OFS_CFG);
  assign statHit = (bus.addr == `BGC_OFS_STAT);
  assign faultHit = (bus.addr == `BGC_OFS_FAULT);

  always_ff @(posedge clk) begin
    if (rst) begin
      highSideCmdBit_q <= '0;
      lowSideCmdBit_q <= '0;
    end else if (bus.wr && ctrlHit) begin
      for (int p = 0; p < NUM_PHASES; p++) begin
        lowSideCmdBit_q[p] <= bus.wdata[2*p];
        highSideCmdBit_q[p] <= bus.wdata[2*p+1];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      directMode_q <= CFG_RST[`BGC_CFG_DIRECT_BIT];
      gateEnSw_q <= CFG_RST[`BGC_CFG_GATE_EN_BIT];
    end else if (bus.wr && cfgHit) begin
      directMode_q <= bus.wdata[`BGC_CFG_DIRECT_BIT];
      gateEnSw_q <= bus.wdata[`BGC_CFG_GATE_EN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // command merge and gate enable
  // ----------------------------------------------------------------
  // pins and bits are ORed; mixing both sources is the user's risk
  bgc_pkg::bgc_pair_s [NUM_PHASES-1:0] cmd;
  always_comb begin
    for (int p = 0; p < NUM_PHASES; p++) begin
      cmd[p].high = hiPin[p] | highSideCmdBit_q[p];
      cmd[p].low = loPin[p] | lowSideCmdBit_q[p];
    end
  end

  logic gateEnable;
  // enable pin only gates drive in direct mode
  assign gateEnable = gateEnSw_q && (!directMode_q || enable);

  bgc_pkg::bgc_phase_e [NUM_PHASES-1:0] phaseState;

  for (genvar p = 0; p < NUM_PHASES; p++) begin : gPhase
    // separate instance per phase keeps them independent
    bgc_phase uPhase (
      .clk(clk),
      .rst(rst),
      .cmd(cmd[p]),
      .gateEnable(gateEnable),
      .highSideGateOut(highSideGateOut[p]),
      .lowSideGateOut(lowSideGateOut[p]),
      .phaseState(phaseState[p])
    );
  end

  // ----------------------------------------------------------------
  // drain-source faults
  // ----------------------------------------------------------------
  // comparators are analog; here they arrive as levels, set beats clear
  logic [NUM_PHASES-1:0] hsClr;
  logic [NUM_PHASES-1:0] lsClr;
  assign hsClr = (bus.wr && faultHit) ?
    bus.wdata[`BGC_FAULT_HS_LSB +: NUM_PHASES] : '0;
  assign lsClr = (bus.wr && faultHit) ?
    bus.wdata[`BGC_FAULT_LS_LSB +: NUM_PHASES] : '0;

  always_ff @(posedge clk) begin
    if (rst) begin
      highSideDsFault <= '0;
    end else begin
      highSideDsFault <= highSideDsOver | (highSideDsFault & ~hsClr);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      lowSideDsFault <= '0;
    end else begin
      lowSideDsFault <= lowSideDsOver | (lowSideDsFault & ~lsClr);
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [31:0] rdata_d;
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (ctrlHit) begin
      for (int p = 0; p < NUM_PHASES; p++) begin
        rdata_d[2*p] = lowSideCmdBit_q[p];
        rdata_d[2*p+1] = highSideCmdBit_q[p];
      end
    end else if (cfgHit) begin
      rdata_d[`BGC_CFG_DIRECT_BIT] = directMode_q;
      rdata_d[`BGC_CFG_GATE_EN_BIT] = gateEnSw_q;
    end else if (statHit) begin
      // gates in 0..7, low gates in 8..15, enable at 16, gate enable 17
      rdata_d = widen(highSideGateOut)
        | (widen(lowSideGateOut) << 8);
      rdata_d[16] = enable;
      rdata_d[17] = gateEnable;
    end else if (faultHit) begin
      rdata_d = (widen(highSideDsFault) << `BGC_FAULT_HS_LSB)
        | (widen(lowSideDsFault) << `BGC_FAULT_LS_LSB);
    end
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      regRdata <= 32'h0000_0000;
    end else if (bus.rd) begin
      regRdata <= rdata_d;
    end else begin
      regRdata <= 32'h0000_0000;
    end
  end

endmodule : bgc_bridge_gate_ctrl

//--- tb/bgc_bridge_gate_ctrl_monitor.sv
// port checker for the bridge gate control top
`include "bgc_consts.svh"
module bgc_bridge_gate_ctrl_monitor #(
  parameter int NUM_PHASES = 3,
  parameter int SYNC_STAGES = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [NUM_PHASES-1:0] highSideCmdPin,
  input wire logic [NUM_PHASES-1:0] lowSideCmdPin,
  input wire logic enablePin,
  input wire logic [NUM_PHASES-1:0] highSideDsOver,
  input wire logic [NUM_PHASES-1:0] lowSideDsOver,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic [NUM_PHASES-1:0] highSideGateOut,
  input wire logic [NUM_PHASES-1:0] lowSideGateOut,
  input wire logic [NUM_PHASES-1:0] highSideDsFault,
  input wire logic [NUM_PHASES-1:0] lowSideDsFault
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int N = NUM_PHASES;
  // ----------------------------------------------------------------
  // expected gates, delayed like the pin and register paths
  // ----------------------------------------------------------------
  logic [2*N:0] pipeQ [SYNC_STAGES+1];
  logic [2*N-1:0] ctrlQ, ctrlD;
  logic [1:0] cfgQ, cfgD;
  logic [N-1:0] hiC, loC, expHs, expLs;
  logic go;
  always_ff @(posedge clk) begin
    pipeQ[0] <= rst ? '0 : {enablePin, highSideCmdPin, lowSideCmdPin};
    for (int i = 1; i <= SYNC_STAGES; i++) begin
      pipeQ[i] <= rst ? '0 : pipeQ[i-1];
    end
  end
  // register writes land one edge before the gate flop sees them
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrlQ <= '0;
      cfgQ <= 2'h1;
    end else if (regWr && regAddr == `BGC_OFS_CTRL) begin
      ctrlQ <= regWdata[2*N-1:0];
    end else if (regWr && regAddr == `BGC_OFS_CFG) begin
      cfgQ <= regWdata[1:0];
    end
    ctrlD <= rst ? '0 : ctrlQ;
    cfgD <= rst ? 2'h1 : cfgQ;
  end
  always_comb begin
    for (int p = 0; p < N; p++) begin
      hiC[p] = pipeQ[SYNC_STAGES][N+p] | ctrlD[2*p+1];
      loC[p] = pipeQ[SYNC_STAGES][p] | ctrlD[2*p];
    end
    go = cfgD[1] & (~cfgD[0] | pipeQ[SYNC_STAGES][2*N]);
    expHs = hiC & ~loC & {N{go}};
    expLs = loC & ~hiC & {N{go}};
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_noShoot; (highSideGateOut & lowSideGateOut) == '0; endproperty
  a_noShoot: assert property (p_noShoot) else $error("both on");
  property p_hsGate; highSideGateOut == expHs; endproperty
  a_hsGate: assert property (p_hsGate) else $error("high gate");
  property p_lsGate; lowSideGateOut == expLs; endproperty
  a_lsGate: assert property (p_lsGate) else $error("low gate");
  property p_offBoth; ((~hiC & ~loC) & (highSideGateOut | lowSideGateOut)) == '0;
  endproperty
  a_offBoth: assert property (p_offBoth) else $error("idle on");
  property p_disable; !go |-> (highSideGateOut | lowSideGateOut) == '0;
  endproperty
  a_disable: assert property (p_disable) else $error("disabled on");
  property p_enPin;
    cfgD[0] && !pipeQ[SYNC_STAGES][2*N] [*2] |->
      (highSideGateOut | lowSideGateOut) == '0;
  endproperty
  a_enPin: assert property (p_enPin) else $error("enable low");
  property p_hsSet; highSideDsOver != '0 |=>
    (highSideDsFault & $past(highSideDsOver)) == $past(highSideDsOver);
  endproperty
  a_hsSet: assert property (p_hsSet) else $error("hs fault");
  property p_lsSet; lowSideDsOver != '0 |=>
    (lowSideDsFault & $past(lowSideDsOver)) == $past(lowSideDsOver);
  endproperty
  a_lsSet: assert property (p_lsSet) else $error("ls fault");
  property p_sticky; !(regWr && regAddr == `BGC_OFS_FAULT) |=>
    ($past(highSideDsFault) & ~highSideDsFault) == '0 &&
    ($past(lowSideDsFault) & ~lowSideDsFault) == '0;
  endproperty
  a_sticky: assert property (p_sticky) else $error("fault lost");
endmodule : bgc_bridge_gate_ctrl_monitor

bind bgc_bridge_gate_ctrl bgc_bridge_gate_ctrl_monitor #(
  .NUM_PHASES(NUM_PHASES),
  .SYNC_STAGES(SYNC_STAGES)
) i_bgc_bridge_gate_ctrl_monitor (.*);

//--- tb/bgc_mcu_model.sv
// controller model: drives phase command pins and enable
module bgc_mcu_model (
  input wire logic clk,
  input wire logic [2:0] wantHigh,
  input wire logic [2:0] wantLow,
  input wire logic wantEn,
  output logic [2:0] highSideCmdPin,
  output logic [2:0] lowSideCmdPin,
  output logic enablePin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {highSideCmdPin, lowSideCmdPin, enablePin} = '0;
  // port register: pins only move just after an edge
  always @(posedge clk) begin
    highSideCmdPin <= wantHigh;
    lowSideCmdPin <= wantLow;
    enablePin <= wantEn;
  end
endmodule : bgc_mcu_model

//--- tb/bgc_bridge_gate_ctrl_tb_top.sv
// self-checking bench for the bridge gate control block
`include "bgc_consts.svh"
`define CHK(a, e) begin nChecks++; if ((a) !== (e)) begin errTotal++; \
  $display("BAD t=%0t got %h exp %h", $time, a, e); end end
module bgc_bridge_gate_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0;
  logic rst = 1;
  logic wantEn = 1, regWr = 0, regRd = 0, enPin;
  logic [2:0] wantHigh = '0, wantLow = '0, hsOver = '0, lsOver = '0;
  logic [2:0] hsPin, lsPin, hsGate, lsGate, hsFlt, lsFlt, eh, el;
  logic [7:0] regAddr = '0;
  logic [31:0] regWdata = '0, regRdata, rv;
  int errTotal = 0, nChecks = 0, seed = 86;
  always #2.5 clk = ~clk;
  bgc_mcu_model i_bgc_mcu_model (.clk(clk), .wantHigh(wantHigh),
    .wantLow(wantLow), .wantEn(wantEn), .highSideCmdPin(hsPin),
    .lowSideCmdPin(lsPin), .enablePin(enPin));
  bgc_bridge_gate_ctrl i_bgc_bridge_gate_ctrl (.clk(clk), .rst(rst),
    .highSideCmdPin(hsPin), .lowSideCmdPin(lsPin), .enablePin(enPin),
    .highSideDsOver(hsOver), .lowSideDsOver(lsOver), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .highSideGateOut(hsGate),
    .lowSideGateOut(lsGate), .highSideDsFault(hsFlt),
    .lowSideDsFault(lsFlt));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [5:0] expGate(logic [2:0] h, l, logic go);
    return {h & ~l, l & ~h} & {6{go}};
  endfunction : expGate
  task automatic finalReport();
    $display("checks %0d mismatches %0d", nChecks, errTotal);
    if (errTotal == 0 && nChecks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finalReport
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    `CHK(regRdata, e)
    @(posedge clk);
  endtask : rd
  // pins need model flop, two sync stages and the gate flop
  task automatic gates(input logic [2:0] h, l, input logic go);
    repeat (6) @(posedge clk);
    @(negedge clk);
    `CHK({hsGate, lsGate}, expGate(h, l, go))
    @(posedge clk);
  endtask : gates
  initial begin
    #(5 * 5000);
    errTotal++;
    finalReport();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(`BGC_OFS_CFG, `BGC_CFG_RST);
    rd(`BGC_OFS_CTRL, `BGC_CTRL_RST);
    rd(8'h10, 32'h0000_0000);
    wantHigh <= 3'h7;
    gates(3'h7, 3'h0, 1'b0);
    $display("test reset done");
    wr(`BGC_OFS_CFG, 32'h0000_0003);
    for (int i = 0; i < 64; i++) begin
      rv = $random(seed);
      wantHigh <= rv[8:6];
      wantLow <= rv[11:9];
      wr(`BGC_OFS_CTRL, {26'h0, rv[5:0]});
      eh = rv[8:6] | {rv[5], rv[3], rv[1]};
      el = rv[11:9] | {rv[4], rv[2], rv[0]};
      gates(eh, el, 1'b1);
    end
    $display("test decode done");
    wr(`BGC_OFS_CTRL, 32'h0000_0000);
    wantHigh <= 3'h7;
    wantLow <= 3'h0;
    wantEn <= 1'b0;
    gates(3'h7, 3'h0, 1'b0);
    rd(`BGC_OFS_STAT, 32'h0000_0000);
    wantEn <= 1'b1;
    gates(3'h7, 3'h0, 1'b1);
    rd(`BGC_OFS_STAT, 32'h0003_0007);
    wr(`BGC_OFS_CFG, 32'h0000_0001);
    gates(3'h7, 3'h0, 1'b0);
    $display("test enable done");
    rv = $random(seed);
    hsOver <= rv[2:0] | 3'h1;
    lsOver <= rv[10:8] | 3'h2;
    @(posedge clk);
    hsOver <= '0;
    lsOver <= '0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK(hsFlt, rv[2:0] | 3'h1)
    `CHK(lsFlt, rv[10:8] | 3'h2)
    @(posedge clk);
    rd(`BGC_OFS_FAULT, {21'h0, rv[10:8] | 3'h2, 5'h0, rv[2:0] | 3'h1});
    // set and clear in one cycle: the set must win
    hsOver <= 3'h1;
    regAddr <= `BGC_OFS_FAULT;
    regWdata <= 32'h0000_0001;
    regWr <= 1'b1;
    @(posedge clk);
    hsOver <= '0;
    regWr <= 1'b0;
    @(negedge clk);
    `CHK(hsFlt[0], 1'b1)
    @(posedge clk);
    wr(`BGC_OFS_FAULT, 32'h0000_0707);
    rd(`BGC_OFS_FAULT, 32'h0000_0000);
    $display("test fault done");
    finalReport();
  end
endmodule : bgc_bridge_gate_ctrl_tb_top
